// File: blc_pkg.sv
// constants shared by the binary led clock design files
// assumes one clock at the nominal rate below; no software registers
package blc_pkg;
  localparam int unsigned CLK_HZ       = 200;
  localparam int unsigned TICK_HZ      = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / TICK_HZ;
  localparam int unsigned TICK_W       = $clog2(TICK_CYCLES);
  localparam int unsigned SEC_W        = 6;
  localparam int unsigned MIN_W        = 6;
  localparam int unsigned HOUR_W       = 5;
  localparam int unsigned COL_W        = 4;
  localparam int unsigned ROW_W        = 3;
  localparam logic [SEC_W-1:0]  SEC_MAX  = 6'h3B;
  localparam logic [MIN_W-1:0]  MIN_MAX  = 6'h3B;
  localparam logic [HOUR_W-1:0] HOUR_MAX = 5'h17;
  localparam logic [ROW_W-1:0]  ROW_IDLE = 3'h7;
  localparam logic [ROW_W-1:0]  ROW_A    = 3'h6;
  localparam logic [ROW_W-1:0]  ROW_B    = 3'h5;
  localparam logic [ROW_W-1:0]  ROW_C    = 3'h3;
  localparam logic [COL_W-1:0]  COL_ZERO = 4'h0;
  // scan phases, gray coded along the scan order
  typedef enum logic [1:0] {
    BLC_PH_A = 2'h0,
    BLC_PH_B = 2'h1,
    BLC_PH_C = 2'h3
  } blc_phase_t;
endpackage

// File: blc_time_if.sv
// time value carrier between the counter chain and the display scanner
// assumes both ends share sys_clk
`timescale 1ns/10ps
interface blc_time_if;
  import blc_pkg::*;
  logic [SEC_W-1:0]  sec;
  logic [MIN_W-1:0]  min;
  logic [HOUR_W-1:0] hour;
  modport prod (output sec, output min, output hour);
  modport cons (input sec, input min, input hour);
endinterface

// File: blc_counter.sv
// cascaded seconds, minutes and hours counters
// assumes tick is a one-cycle pulse and hour_load a one-cycle load strobe
`timescale 1ns/10ps
module blc_counter
  import blc_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  // control
  input  wire logic              tick,
  input  wire logic              hour_load,
  input  wire logic [HOUR_W-1:0] hour_preset,
  // time out
  blc_time_if.prod               tm
);
  logic [SEC_W-1:0]  sec_reg,  sec_next;
  logic [MIN_W-1:0]  min_reg,  min_next;
  logic [HOUR_W-1:0] hour_reg, hour_next;
  logic              sec_ovf, min_ovf;

  always_comb begin
    sec_next  = sec_reg;
    min_next  = min_reg;
    hour_next = hour_reg;
    sec_ovf   = tick && (sec_reg == SEC_MAX);
    min_ovf   = sec_ovf && (min_reg == MIN_MAX);
    if (tick) begin
      sec_next = sec_ovf ? '0 : sec_reg + 1'b1;
    end
    if (sec_ovf) begin
      min_next = min_ovf ? '0 : min_reg + 1'b1;
    end
    if (min_ovf) begin
      hour_next = (hour_reg == HOUR_MAX) ? '0 : hour_reg + 1'b1;
    end
    // the preset wins; it only arrives right after reset
    if (hour_load) begin
      hour_next = hour_preset;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_reg  <= '0;
      min_reg  <= '0;
      hour_reg <= '0;
    end else begin
      sec_reg  <= sec_next;
      min_reg  <= min_next;
      hour_reg <= hour_next;
    end
  end

  assign tm.sec  = sec_reg;
  assign tm.min  = min_reg;
  assign tm.hour = hour_reg;
endmodule

// File: blc_top.sv
// binary led clock: time counters and a 3-row by 4-column led scanner
// assumes pps is synchronous to sys_clk and held low when unused
//
// Function
// - cascaded counters; overflow advances next counter
// - twelve leds driven by seven lines
// - hour counter loads preset leaving reset
// - display hours, minute bits 4:0 and seconds bit
// - rows scan 110, 101, 011, one low
// - columns carry minute, hour, seconds bits
// - zero preset after reset shows zeros
// - after one second row A shows 0001
// - each pps rising edge after the hour preset load cycle advances seconds
`timescale 1ns/10ps
module blc_top
  import blc_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // time source
  input  wire logic             pps,
  // hour preset, sampled as reset is released
  input  wire logic             hour_preset_bit0,
  input  wire logic             hour_preset_bit1,
  input  wire logic             hour_preset_bit2,
  input  wire logic             hour_preset_bit3,
  input  wire logic             hour_preset_bit4,
  // led matrix
  output logic      [COL_W-1:0] cols,
  output logic      [ROW_W-1:0] rows
);
  // divider width follows the parameter so a long divide cannot truncate
  localparam int unsigned DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;

  blc_time_if tm ();

  logic              pps_reg,  pps_next;
  logic              load_reg, load_next;
  logic [DIV_W-1:0]  div_reg,  div_next;
  logic              pps_rise, div_wrap, tick;
  blc_phase_t        ph_reg,   ph_next;
  logic [COL_W-1:0]  cols_reg, cols_next;
  logic [ROW_W-1:0]  rows_reg, rows_next;
  logic [HOUR_W-1:0] hour_preset;

  assign hour_preset = {hour_preset_bit4, hour_preset_bit3,
                        hour_preset_bit2, hour_preset_bit1,
                        hour_preset_bit0};

  // tick generation: a pps edge also restarts the divider so that an
  // attached time source keeps the internal tick from firing in between
  always_comb begin
    pps_next  = pps;
    load_next = 1'b0;
    pps_rise  = pps && !pps_reg;
    div_wrap  = (div_reg == DIV_W'(TICK_DIV - 1));
    tick      = pps_rise || div_wrap;
    if (pps_rise || div_wrap) begin
      div_next = '0;
    end else begin
      div_next = div_reg + 1'b1;
    end
  end

  // load_reg is set by reset and drops at the first edge after release,
  // so the preset is caught by a clocked load, never by the reset itself
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pps_reg  <= 1'b0;
      load_reg <= 1'b1;
      div_reg  <= '0;
    end else begin
      pps_reg  <= pps_next;
      load_reg <= load_next;
      div_reg  <= div_next;
    end
  end

  blc_counter u_counter (
    .sys_clk     (sys_clk),
    .arst_n      (arst_n),
    .tick        (tick && !load_reg),
    .hour_load   (load_reg),
    .hour_preset (hour_preset),
    .tm          (tm.prod)
  );

  function automatic logic [COL_W-1:0] col_bits(
    input blc_phase_t        ph,
    input logic [SEC_W-1:0]  s,
    input logic [MIN_W-1:0]  m,
    input logic [HOUR_W-1:0] h
  );
    case (ph)
      BLC_PH_A: col_bits = {m[2:0], s[0]};
      BLC_PH_B: col_bits = {h[1:0], m[4:3]};
      BLC_PH_C: col_bits = {1'b0, h[4:2]};
      default:  col_bits = COL_ZERO;
    endcase
  endfunction

  function automatic logic [ROW_W-1:0] row_bits(input blc_phase_t ph);
    case (ph)
      BLC_PH_A: row_bits = ROW_A;
      BLC_PH_B: row_bits = ROW_B;
      BLC_PH_C: row_bits = ROW_C;
      default:  row_bits = ROW_IDLE;
    endcase
  endfunction

  // one row per clock; at 200 Hz a full frame takes 15 ms, flicker free
  always_comb begin
    case (ph_reg)
      BLC_PH_A: ph_next = BLC_PH_B;
      BLC_PH_B: ph_next = BLC_PH_C;
      BLC_PH_C: ph_next = BLC_PH_A;
      default:  ph_next = BLC_PH_A;
    endcase
    rows_next = row_bits(ph_reg);
    cols_next = col_bits(ph_reg, tm.sec, tm.min, tm.hour);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg   <= BLC_PH_A;
      rows_reg <= ROW_IDLE;
      cols_reg <= COL_ZERO;
    end else begin
      ph_reg   <= ph_next;
      rows_reg <= rows_next;
      cols_reg <= cols_next;
    end
  end

  assign cols = cols_reg;
  assign rows = rows_reg;
endmodule

// File: blc_top_props.sv
// assertions on the binary led clock top ports
// assumes one clock domain and a preset held steady after reset
`timescale 1ns/10ps
module blc_top_chk
  import blc_pkg::*;
#(parameter int unsigned TICK_DIV = TICK_CYCLES)
(
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             arst_n,
  // inputs
  input wire logic             pps,
  input wire logic             hour_preset_bit0,
  input wire logic             hour_preset_bit1,
  input wire logic             hour_preset_bit2,
  input wire logic             hour_preset_bit3,
  input wire logic             hour_preset_bit4,
  // outputs
  input wire logic [COL_W-1:0] cols,
  input wire logic [ROW_W-1:0] rows
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // edges since release, saturating so it never wraps back to the start
  logic [2:0] cyc_reg;
  logic [2:0] cyc_next;
  always_comb cyc_next = (cyc_reg == 3'h7) ? cyc_reg : cyc_reg + 3'h1;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      cyc_reg <= 3'h0;
    else
      cyc_reg <= cyc_next;
  end
  property p_ab; rows == ROW_A |=> rows == ROW_B; endproperty
  a_ab: assert property (p_ab) else $error("row b missing");
  property p_bc; rows == ROW_B |=> rows == ROW_C; endproperty
  a_bc: assert property (p_bc) else $error("row c missing");
  property p_ca; rows == ROW_C |=> rows == ROW_A; endproperty
  a_ca: assert property (p_ca) else $error("row a missing");
  property p_ia; rows == ROW_IDLE |=> rows == ROW_A; endproperty
  a_ia: assert property (p_ia) else $error("scan start");
  property p_ctop; rows == ROW_C |-> !cols[3]; endproperty
  a_ctop: assert property (p_ctop) else $error("row c top bit");
  property p_first; cyc_reg == 3'h1 |-> cols == COL_ZERO; endproperty
  a_first: assert property (p_first) else $error("first scan");
  property p_hlo; cyc_reg == 3'h2 |-> cols ==
    {hour_preset_bit1, hour_preset_bit0, 2'h0}; endproperty
  a_hlo: assert property (p_hlo) else $error("hour low bits");
  property p_hhi; cyc_reg == 3'h3 |-> cols ==
    {1'b0, hour_preset_bit4, hour_preset_bit3, hour_preset_bit2};
  endproperty
  a_hhi: assert property (p_hhi) else $error("hour high bits");
  // a tick as row a is latched shows on the next row a, three clocks on
  property p_pps; $rose(pps) && !$past(pps, 2) && rows == ROW_C
    ##1 !$rose(pps) ##1 !$rose(pps)
    |-> ##2 cols[0] != $past(cols[0], 3); endproperty
  a_pps: assert property (p_pps) else $error("pps no step");
endmodule
bind blc_top blc_top_chk #(.TICK_DIV(TICK_DIV)) i_chk (.sys_clk(sys_clk),
  .arst_n(arst_n), .pps(pps), .hour_preset_bit0(hour_preset_bit0),
  .hour_preset_bit1(hour_preset_bit1), .hour_preset_bit2(hour_preset_bit2),
  .hour_preset_bit3(hour_preset_bit3), .hour_preset_bit4(hour_preset_bit4),
  .cols(cols), .rows(rows));

// File: blc_pps_src.sv
// pulse-per-second source in place of an external time reference
// assumes sys_clk is the block clock; pps idles low as if pulled down
`timescale 1ns/10ps
module blc_pps_src (
  // clock
  input  wire logic sys_clk,
  // pulse out
  output logic      pps
);
  initial pps = 1'b0;
  // gap 0 is the fastest spacing the block accepts
  task automatic burst(input int n, input int gap);
    repeat (n) begin
      @(negedge sys_clk) pps = 1'b1;
      @(negedge sys_clk) pps = 1'b0;
      repeat (gap) @(negedge sys_clk);
    end
  endtask
endmodule

// File: tb_binary_led_clock.sv
// testbench for the binary led clock top
// assumes blc_top, blc_pps_src and the bound checker are compiled
`timescale 1ns/10ps
module tb_binary_led_clock;
  import blc_pkg::*;
  logic             sys_clk;
  logic             arst_n = 1'b0;
  logic [4:0]       preset = 5'h00;
  logic             pps;
  logic [COL_W-1:0] cols;
  logic [ROW_W-1:0] rows;
  int               failures = 0;
  int               num_checks = 0;
  blc_pps_src i_pps (.sys_clk(sys_clk), .pps(pps));
  blc_top #(.TICK_DIV(50)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .pps(pps), .hour_preset_bit0(preset[0]), .hour_preset_bit1(preset[1]),
    .hour_preset_bit2(preset[2]), .hour_preset_bit3(preset[3]),
    .hour_preset_bit4(preset[4]), .cols(cols), .rows(rows));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [3:0] e,
                     input logic [3:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic do_reset(input logic [4:0] p);
    @(negedge sys_clk);
    arst_n = 1'b0;
    preset = p;
    repeat (12) @(negedge sys_clk);
    arst_n = 1'b1;
  endtask
  task automatic scan(input logic [3:0] a, input logic [3:0] b,
                      input logic [3:0] c);
    int i;
    i = 0;
    while (rows !== ROW_A && i < 4) begin
      @(negedge sys_clk);
      i++;
    end
    chk("row a", {1'b0, ROW_A}, {1'b0, rows});
    chk("cols a", a, cols);
    @(negedge sys_clk);
    chk("cols b", b, cols);
    @(negedge sys_clk);
    chk("row c", {1'b0, ROW_C}, {1'b0, rows});
    chk("cols c", c, cols);
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    complete_run();
  end
  // divider is 50 here: no tick by the row a at edge 46, one by edge 61
  task automatic test_reset_tick;
    do_reset(5'h00);
    scan(4'h0, 4'h0, 4'h0);
    repeat (42) @(negedge sys_clk);
    scan(4'h0, 4'h0, 4'h0);
    repeat (12) @(negedge sys_clk);
    scan(4'h1, 4'h0, 4'h0);
    $display("test reset and internal tick done");
  endtask
  task automatic test_hour_preset;
    do_reset(5'h13);
    scan(4'h0, 4'hC, 4'h4);
    $display("test hour preset done");
  endtask
  // four spaced pulses so one of them meets each scan phase
  task automatic test_pps_count;
    do_reset(5'h01);
    i_pps.burst(60, 0);
    i_pps.burst(4, 3);
    scan(4'h2, 4'h4, 4'h0);
    $display("test pps count done");
  endtask
  task automatic test_wrap;
    do_reset(5'h17);
    i_pps.burst(3601, 0);
    scan(4'h1, 4'h0, 4'h0);
    $display("test wrap done");
  endtask
  initial begin
    test_reset_tick();
    test_hour_preset();
    test_pps_count();
    test_wrap();
    complete_run();
  end
endmodule
